/* ecr_top.sv */
// Excitation source routing, automatic rotation sequencer and its APB register file.
`timescale 1ns/100ps
module ecr_top #(
    parameter int DW = 32
) (
    // Clock, reset and clock enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter handshake.
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [DW-1:0] conv_data,
    // Output results.
    output logic result_valid,
    output logic [DW-1:0] result_data,
    // Analog switch and reference controls.
    output logic [ecr_pkg::NPINS-1:0] excitation_source_a,
    output logic [ecr_pkg::NPINS-1:0] excitation_source_b,
    output logic ref_enable
);

    // Pin index to one-hot switch pattern; indexes above the last pin close no switch.
    function automatic logic [ecr_pkg::NPINS-1:0] pin_onehot(input logic [3:0] idx,
                                                              input logic en);
        logic [ecr_pkg::NPINS-1:0] v;
        v = '0;
        for (int i = 0; i < ecr_pkg::NPINS; i++) begin
            if (en && idx == 4'(i)) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction

    logic [4:0] first_mode_config_register;
    logic [9:0] src_cfg;
    logic [1:0] ctrl;
    logic res_ready;
    logic [4:0] next_mode;
    logic [9:0] next_src;
    logic [1:0] next_ctrl;
    logic next_res_ready;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic wr_go;
    logic rd_res;

    ecr_pkg::ecr_state_e state;
    ecr_pkg::ecr_state_e next_state;
    logic swapped;
    logic first_pend;
    logic [11:0] cnt;
    logic next_swapped;
    logic next_first;
    logic [11:0] next_cnt;
    logic next_conv_start;
    logic next_result_valid;
    logic [DW-1:0] next_result_data;
    logic [DW-1:0] avg;
    logic [ecr_pkg::NPINS-1:0] next_src_a;
    logic [ecr_pkg::NPINS-1:0] next_src_b;
    logic rot;
    logic run;
    logic done_now;
    logic [3:0] delay;
    logic [11:0] settle_load;

    assign rot = first_mode_config_register[ecr_pkg::ROT_BIT];
    assign delay = first_mode_config_register[ecr_pkg::DELAY_LSB +: 4];
    assign run = ctrl[ecr_pkg::RUN_BIT];
    assign done_now = (state == ecr_pkg::ECR_CONV) && conv_done;
    // Built-in settling plus the programmed extra steps; max total stays under 4096 cycles.
    assign settle_load = ecr_pkg::SETTLE_CYC + {8'h00, delay} * ecr_pkg::STEP_CYC;
    assign wr_go = psel && penable && pready && pwrite;
    assign rd_res = psel && penable && pready && !pwrite && paddr == ecr_pkg::RES_OFS;

    ecr_avg #(
        .DW(DW)
    ) u_avg (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .load(done_now),
        .cur(conv_data),
        .avg(avg)
    );

    // APB: one wait state, then pready; reads load prdata on the edge that raises pready, writes land one edge later.
    always_comb begin
        next_mode = first_mode_config_register;
        next_src = src_cfg;
        next_ctrl = ctrl;
        next_pready = psel && penable && !pready;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (psel && penable && !pready) begin
            next_prdata = 32'h0000_0000;
            case (paddr)
                ecr_pkg::MODE_OFS: next_prdata = {27'h0, first_mode_config_register};
                ecr_pkg::SRC_OFS: next_prdata = {22'h0, src_cfg};
                ecr_pkg::CTRL_OFS: next_prdata = {30'h0, ctrl};
                ecr_pkg::STAT_OFS: next_prdata = {27'h0, res_ready, first_pend, swapped, state};
                ecr_pkg::RES_OFS: next_prdata = 32'(result_data);
                default: next_pslverr = 1'b1;
            endcase
            if (pwrite) begin
                next_prdata = prdata;
            end
        end
        if (wr_go) begin
            case (paddr)
                ecr_pkg::MODE_OFS: next_mode = pwdata[4:0];
                ecr_pkg::SRC_OFS: next_src = pwdata[9:0];
                ecr_pkg::CTRL_OFS: next_ctrl = pwdata[1:0];
                default: next_mode = first_mode_config_register;
            endcase
        end
        // A new result in the same cycle as the read that clears the flag keeps it set.
        next_res_ready = (res_ready && !rd_res) || next_result_valid;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_mode_config_register <= ecr_pkg::MODE_RST;
            src_cfg <= ecr_pkg::SRC_RST;
            ctrl <= ecr_pkg::CTRL_RST;
            res_ready <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            first_mode_config_register <= next_mode;
            src_cfg <= next_src;
            ctrl <= next_ctrl;
            res_ready <= next_res_ready;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Sequencer: start, wait for the converter, average or pass, swap and settle.
    always_comb begin
        next_state = state;
        next_swapped = swapped;
        next_first = first_pend;
        next_cnt = cnt;
        next_conv_start = 1'b0;
        next_result_valid = 1'b0;
        next_result_data = result_data;
        case (state)
            ecr_pkg::ECR_IDLE: begin
                next_swapped = 1'b0;
                next_first = 1'b1;
                if (run) begin
                    next_conv_start = 1'b1;
                    next_state = ecr_pkg::ECR_CONV;
                end
            end
            ecr_pkg::ECR_CONV: begin
                if (!run) begin
                    next_state = ecr_pkg::ECR_IDLE;
                end else if (conv_done && rot) begin
                    if (first_pend) begin
                        next_first = 1'b0;
                    end else begin
                        next_result_valid = 1'b1;
                        next_result_data = avg;
                    end
                    next_swapped = !swapped;
                    next_cnt = settle_load;
                    next_state = ecr_pkg::ECR_SETTLE;
                end else if (conv_done) begin
                    next_swapped = 1'b0;
                    next_first = 1'b1;
                    next_result_valid = 1'b1;
                    next_result_data = conv_data;
                    next_conv_start = 1'b1;
                end
            end
            ecr_pkg::ECR_SETTLE: begin
                // Only the start of the next conversion is held off; the filter runs untouched.
                if (!run) begin
                    next_state = ecr_pkg::ECR_IDLE;
                end else if (cnt <= 12'h001) begin
                    next_conv_start = 1'b1;
                    next_state = ecr_pkg::ECR_CONV;
                end else begin
                    next_cnt = cnt - 12'h001;
                end
            end
            default: next_state = ecr_pkg::ECR_IDLE;
        endcase
    end

    // Switch patterns follow the swap flag; settling of at least one cycle covers the lag.
    always_comb begin
        if (swapped) begin
            next_src_a = pin_onehot(src_cfg[ecr_pkg::SRC_B_LSB +: 4], src_cfg[ecr_pkg::EN_A_BIT]);
            next_src_b = pin_onehot(src_cfg[ecr_pkg::SRC_A_LSB +: 4], src_cfg[ecr_pkg::EN_B_BIT]);
        end else begin
            next_src_a = pin_onehot(src_cfg[ecr_pkg::SRC_A_LSB +: 4], src_cfg[ecr_pkg::EN_A_BIT]);
            next_src_b = pin_onehot(src_cfg[ecr_pkg::SRC_B_LSB +: 4], src_cfg[ecr_pkg::EN_B_BIT]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ecr_pkg::ECR_IDLE;
            swapped <= 1'b0;
            first_pend <= 1'b1;
            cnt <= 12'h000;
            conv_start <= 1'b0;
            result_valid <= 1'b0;
            result_data <= '0;
            excitation_source_a <= '0;
            excitation_source_b <= '0;
            ref_enable <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            swapped <= next_swapped;
            first_pend <= next_first;
            cnt <= next_cnt;
            conv_start <= next_conv_start;
            result_valid <= next_result_valid;
            result_data <= next_result_data;
            excitation_source_a <= next_src_a;
            excitation_source_b <= next_src_b;
            ref_enable <= next_ctrl[ecr_pkg::REFEN_BIT];
        end
    end

    // Checks on the sequencer and routing.
    sequence s_rot_done;
        ce && done_now && run && rot;
    endsequence

    sequence s_enter_settle;
        ce && state == ecr_pkg::ECR_CONV && next_state == ecr_pkg::ECR_SETTLE;
    endsequence

    property p_pins_onehot;
        @(posedge pclk) disable iff (!presetn)
        $onehot0(excitation_source_a) && $onehot0(excitation_source_b);
    endproperty
    a_pins_onehot: assert property (p_pins_onehot) else $error("Source drives two pins.");

    property p_swap_each;
        @(posedge pclk) disable iff (!presetn)
        s_rot_done |=> swapped != $past(swapped) ##1
            (!$past(ce) || excitation_source_a == $past(next_src_a));
    endproperty
    a_swap_each: assert property (p_swap_each) else $error("No swap after conversion.");

    property p_first_held;
        @(posedge pclk) disable iff (!presetn)
        s_rot_done and first_pend |=> !result_valid && !first_pend;
    endproperty
    a_first_held: assert property (p_first_held) else $error("First result not withheld.");

    property p_avg_out;
        @(posedge pclk) disable iff (!presetn)
        s_rot_done and !first_pend |=> result_valid && result_data == $past(avg);
    endproperty
    a_avg_out: assert property (p_avg_out) else $error("Averaged result wrong.");

    property p_swap_cause;
        @(posedge pclk) disable iff (!presetn)
        $changed(swapped) |-> $past(done_now) || $past(state) == ecr_pkg::ECR_IDLE
            || !$past(rot);
    endproperty
    a_swap_cause: assert property (p_swap_cause) else $error("Swap without conversion.");

    property p_settle_load;
        @(posedge pclk) disable iff (!presetn)
        s_enter_settle |=> cnt == $past(settle_load) && cnt >= ecr_pkg::SETTLE_CYC;
    endproperty
    a_settle_load: assert property (p_settle_load) else $error("Settle count wrong.");

    property p_settle_quiet;
        @(posedge pclk) disable iff (!presetn)
        s_enter_settle ##1 (ce && run) [*8] |-> !conv_start;
    endproperty
    a_settle_quiet: assert property (p_settle_quiet) else $error("Start during settle.");

    property p_direct;
        @(posedge pclk) disable iff (!presetn)
        ce && done_now && run && !rot |=> result_valid && result_data == $past(conv_data)
            && conv_start && !swapped;
    endproperty
    a_direct: assert property (p_direct) else $error("Direct result not delivered.");

endmodule

/* ecr_pkg.sv */
// Constants, register map and state encoding for the excitation current rotation block.
// How it works
// - Two matched excitation sources can each be routed to any one of eleven analog pins.
// - With rotation on, the two sources swap pins after every conversion, with no software help.
// - The first conversion of a rotation run uses normal positions and gives no result.
// - Each later result is the sum of the latest conversion and the one before, halved.
// - Rotation runs on forever: odd conversions normal, even ones swapped, each pair averaged.
// - After every swap a built-in settling delay passes before the next conversion starts.
// - A four-bit delay field in the first mode register adds extra settling after a swap.
// - The settling delay slows the conversion rate but leaves the filter nulls unchanged.
package ecr_pkg;

    // Clock and settling times.
    localparam int CLK_NS = 4;
    localparam int SETTLE_NS = 400;
    localparam int STEP_NS = 1000;
    localparam logic [11:0] SETTLE_CYC = 12'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] STEP_CYC = 12'((STEP_NS + CLK_NS - 1) / CLK_NS);

    // Pins: index 10 is the common analog pin, index 0 analog input zero.
    localparam int NPINS = 11;
    localparam logic [3:0] COMMON_PIN = 4'ha;

    // Register byte addresses.
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] SRC_OFS = 8'h04;
    localparam logic [7:0] CTRL_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0c;
    localparam logic [7:0] RES_OFS = 8'h10;

    // Field positions.
    localparam int DELAY_LSB = 0;
    localparam int ROT_BIT = 4;
    localparam int SRC_A_LSB = 0;
    localparam int SRC_B_LSB = 4;
    localparam int EN_A_BIT = 8;
    localparam int EN_B_BIT = 9;
    localparam int RUN_BIT = 0;
    localparam int REFEN_BIT = 1;
    localparam int ST_SWAP_BIT = 2;
    localparam int ST_FIRST_BIT = 3;
    localparam int ST_READY_BIT = 4;

    // Reset values.
    localparam logic [4:0] MODE_RST = 5'h00;
    localparam logic [9:0] SRC_RST = 10'h010;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // Sequencer states.
    typedef enum logic [1:0] {
        ECR_IDLE = 2'b00,
        ECR_CONV = 2'b01,
        ECR_SETTLE = 2'b10
    } ecr_state_e;

endpackage

/* ecr_avg.sv */
// Pair averager that keeps the previous conversion and halves the sum with the current one.
`timescale 1ns/100ps
module ecr_avg #(
    parameter int DW = 32
) (
    // Clock, reset and enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Conversion stream.
    input wire logic load,
    input wire logic [DW-1:0] cur,
    // Average of current and previous conversion.
    output logic [DW-1:0] avg
);

    logic [DW-1:0] prev;
    logic [DW-1:0] next_prev;
    logic signed [DW:0] sum;

    // The previous word moves on with every finished conversion.
    always_comb begin
        next_prev = prev;
        if (load) begin
            next_prev = cur;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= '0;
        end else if (ce) begin
            prev <= next_prev;
        end
    end

    // One extra bit keeps the sum exact; the shift is a signed floor divide by two.
    always_comb begin
        sum = $signed({cur[DW-1], cur}) + $signed({prev[DW-1], prev});
        avg = sum[DW:1];
    end

endmodule

/* ecr_sensor.sv */
// Converter and sensor model that answers each conversion start with one data word.
`timescale 1ns/100ps
module ecr_sensor #(
    parameter int LAT = 20
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Converter handshake.
    input wire logic conv_start,
    output logic conv_done,
    output logic [31:0] conv_data,
    // Switch enable of source a as seen by the sensor.
    input wire logic [10:0] excitation_source_a
);
    int cnt;
    int num;
    logic mark;
    logic [31:0] last;
    // The data word is a count plus a mark of five while source a feeds pin two.
    // The bus shows the inverse of the last word outside the done pulse.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            num <= 0;
            mark <= 1'b0;
            conv_done <= 1'b0;
            last <= 32'h0;
            conv_data <= 32'hffffffff;
        end else begin
            conv_done <= 1'b0;
            conv_data <= ~last;
            if (conv_start === 1'b1) begin
                cnt <= LAT;
                mark <= excitation_source_a[2];
            end else if (cnt == 1) begin
                cnt <= 0;
                num <= num + 1;
                conv_done <= 1'b1;
                last <= 32'(16 * num - 48) + (mark ? 32'h5 : 32'h0);
                conv_data <= 32'(16 * num - 48) + (mark ? 32'h5 : 32'h0);
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

/* excitation_current_rotation_tb.sv */
// Self-checking bench for the excitation current rotation block.
`timescale 1ns/100ps
module excitation_current_rotation_tb;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} ecr_row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, conv_start, conv_done, result_valid;
    logic [31:0] conv_data, result_data, curd, prevd, rd;
    logic [10:0] src_a, src_b;
    logic ref_enable, er, rot;
    logic ce = 1'b1;
    int num_errors = 0;
    int comparisons = 0;
    int nconv, nres, gap, dly;
    ecr_row_s rows[9] = '{
        '{8'h00, 0, 0, 32'h0, 0}, '{8'h04, 0, 0, 32'h010, 0}, '{8'h08, 0, 0, 32'h0, 0},
        '{8'h0c, 0, 0, 32'h08, 0}, '{8'h14, 0, 0, 32'h0, 1}, '{8'h0c, 1, 32'hff, 0, 0},
        '{8'h0c, 0, 0, 32'h08, 0}, '{8'h00, 1, 32'h1f, 0, 0}, '{8'h00, 0, 0, 32'h1f, 0}};

    ecr_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_start(conv_start), .conv_done(conv_done),
        .conv_data(conv_data), .result_valid(result_valid), .result_data(result_data),
        .excitation_source_a(src_a), .excitation_source_b(src_b), .ref_enable(ref_enable));
    ecr_sensor #(.LAT(20)) sensor (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
        .conv_done(conv_done), .conv_data(conv_data), .excitation_source_a(src_a));

    // Half period of 2 ns gives the 250 MHz clock.
    always #2 pclk = ~pclk;

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    // Request is held until pready is seen high at an edge, then released.
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // No wait limit here: only the watchdog may end a stalled transfer.
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Run from a clean monitor state and wait for a number of results.
    task run(input logic [31:0] mode, input int want);
        int n;
        n = 0;
        apb(8'h00, 1, mode);
        rot = mode[4];
        dly = int'(mode[3:0]);
        nconv = 0;
        nres = 0;
        apb(8'h08, 1, 32'h3);
        while (nres < want && n < 20000) begin
            n++;
            @(posedge pclk);
        end
        chk(32'(nres), 32'(want), "result count");
        chk(32'(nconv - nres), rot ? 32'h1 : 32'h0, "withheld count");
        apb(8'h08, 1, 32'h2);
        repeat (40) @(posedge pclk);
    endtask

    // Watches the converter side, the swap pattern, the settle gap and each result.
    always @(posedge pclk) begin
        logic signed [32:0] s;
        gap++;
        if (conv_start === 1'b1 && rot && nconv > 0) begin
            if (gap < 100 + 250 * dly || gap > 104 + 250 * dly) begin
                chk(32'(gap), 32'(100 + 250 * dly), "settle gap");
            end
        end
        if (conv_done === 1'b1) begin
            nconv++;
            gap = 0;
            prevd = curd;
            curd = conv_data;
            chk({31'h0, conv_data[3:0] == 4'h5}, {31'h0, !rot || nconv[0]}, "swap");
        end
        if (result_valid === 1'b1) begin
            nres++;
            s = $signed({curd[31], curd}) + $signed({prevd[31], prevd});
            chk(result_data, rot ? s[32:1] : curd, "result");
        end
    end

    task wrap_up;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // The tests need a few thousand cycles; the watchdog allows far more.
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end

    initial begin
        rot = 1'b0;
        dly = 0;
        gap = 0;
        curd = 32'h0;
        prevd = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            chk({31'h0, er}, {31'h0, rows[i].e}, "error response");
            if (!rows[i].w) chk(rd, rows[i].x, "read back");
        end
        chk({10'h0, src_a, src_b}, 32'h0, "switches off at reset");
        apb(8'h04, 1, 32'h352);
        repeat (2) @(posedge pclk);
        chk({21'h0, src_a}, 32'h004, "source a on pin two");
        chk({21'h0, src_b}, 32'h020, "source b on pin five");
        // Swap the pins by hand; a low clock enable must hold the switches meanwhile.
        apb(8'h04, 1, 32'h325);
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({21'h0, src_a}, 32'h004, "switches frozen while enable low");
        ce <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({21'h0, src_a}, 32'h020, "source a moved by hand");
        chk({21'h0, src_b}, 32'h004, "source b moved by hand");
        apb(8'h04, 1, 32'h352);
        repeat (2) @(posedge pclk);
        run(32'h00, 3);
        chk({31'h0, ref_enable}, 32'h1, "reference enable");
        run(32'h10, 5);
        run(32'h11, 3);
        // Reset in the middle of a rotation run must clear the swap and re-arm withholding.
        nconv = 0;
        apb(8'h08, 1, 32'h3);
        repeat (30) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({21'h0, src_a}, 32'h0, "switches off in reset");
        chk({29'h0, ref_enable, conv_start, result_valid}, 32'h0, "controls off in reset");
        presetn <= 1'b1;
        apb(8'h08, 0, 32'h0);
        chk(rd, 32'h0, "control cleared by reset");
        apb(8'h0c, 0, 32'h0);
        chk(rd, 32'h08, "status after reset");
        wrap_up();
    end
endmodule
